/* logic/coi_regs.vh */
// Constants for the console output sequence interpreter
// How it works
// - Numeric parameters arrive as ASCII decimal digits and are converted here.
// - No blanks are expected or skipped inside a control sequence.
// - Rendition 30..37 sets foreground black,red,green,yellow,blue,magenta,cyan,white.
// - Rendition 40..47 sets background colour in the same order.
// - Several parameters apply in order; attributes persist until next rendition or until a ';' in any other sequence applies its parameter.
// - Rendition 0 clears, 1 bold, 4 underscore, 7 reverse video.
// - Null is ignored outside a sequence; inside an escape or control sequence it aborts the sequence.
// - Bell raises a one-cycle bell request.
// - Backspace moves left one column, not past the left margin.
// - Tab goes to next eighth-column stop or right margin, never wraps.
// - Screen is 25 by 80; overflow is dropped; stops start at column 9.
// - Line feed, vertical tab and form feed all do a new line.
// - Carriage return moves to left margin on the same line.
// - Input is never throttled; no flow control.
// - Wide codes 0x0020..0x007E produce printable glyphs.
// - Wide codes 0x2500..0x257F produce line drawing glyphs.
// - Codes without a glyph show a substitute error glyph.
// - After printing, cursor moves per the character direction.
// - Wide mode uses the same sequences with zero-extended codes.
// - Both modes start sequences with ESC [ or with the single introducer 0x009B.
`ifndef COI_REGS_VH
`define COI_REGS_VH
`define COI_ROWS 7'd25
`define COI_COLS 7'd80
`define COI_LAST_ROW 7'd24
`define COI_LAST_COL 7'd79
`define COI_TAB_MASK 7'h07
`define COI_TAB_STEP 7'd8
`define COI_C_NUL 16'h0000
`define COI_C_BEL 16'h0007
`define COI_C_BS 16'h0008
`define COI_C_HT 16'h0009
`define COI_C_LF 16'h000A
`define COI_C_VT 16'h000B
`define COI_C_FF 16'h000C
`define COI_C_CR 16'h000D
`define COI_C_ESC 16'h001B
`define COI_C_LBR 16'h005B
`define COI_C_CSI 16'h009B
`define COI_C_SEMI 16'h003B
`define COI_C_D0 16'h0030
`define COI_C_D9 16'h0039
`define COI_C_FIN_LO 16'h0040
`define COI_C_FIN_HI 16'h007E
`define COI_C_SP 16'h0020
`define COI_C_TILDE 16'h007E
`define COI_BOX_LO 16'h2500
`define COI_BOX_HI 16'h257F
`define COI_LAT_LO 16'h00A0
`define COI_LAT_HI 16'h00FF
`define COI_ERR_GLYPH 16'h2592
`define COI_F_H 16'h0048
`define COI_F_F 16'h0066
`define COI_F_A 16'h0041
`define COI_F_B 16'h0042
`define COI_F_C 16'h0043
`define COI_F_D 16'h0044
`define COI_F_J 16'h004A
`define COI_F_K 16'h004B
`define COI_F_M 16'h006D
`define COI_SGR_OFF 8'd0
`define COI_SGR_BOLD 8'd1
`define COI_SGR_UL 8'd4
`define COI_SGR_REV 8'd7
`define COI_SGR_FG_LO 8'd30
`define COI_SGR_FG_HI 8'd37
`define COI_SGR_BG_LO 8'd40
`define COI_SGR_BG_HI 8'd47
`define COI_FG_RST 3'h7
`define COI_BG_RST 3'h0
`define COI_PMAX 8'd255
`define COI_ST_GND 2'd0
`define COI_ST_ESC 2'd1
`define COI_ST_PAR 2'd2
`define COI_ER_EOS 2'd0
`define COI_ER_BOS 2'd1
`define COI_ER_ALL 2'd2
`endif

/* logic/coi_glyph_map.v */
// Glyph availability and substitution for one character code
`timescale 1ns/1ps
`default_nettype none
`include "coi_regs.vh"
module coi_glyph_map (
  input wire [15:0] code,
  input wire wide_mode,
  output reg [15:0] glyph,
  output reg substituted
);
  // ----------------------------------------------------------------
  // Font coverage
  // ----------------------------------------------------------------
  // Byte mode also covers upper Latin; wide mode only the two blocks.
  always @* begin
    glyph = code;
    substituted = 1'b0;
    if (code >= `COI_C_SP && code <= `COI_C_TILDE) begin
      glyph = code;
    end else if (wide_mode && code >= `COI_BOX_LO &&
                 code <= `COI_BOX_HI) begin
      glyph = code;
    end else if (!wide_mode && code >= `COI_LAT_LO &&
                 code <= `COI_LAT_HI) begin
      glyph = code;
    end else begin
      glyph = `COI_ERR_GLYPH;
      substituted = 1'b1;
    end
  end
endmodule // coi_glyph_map
`default_nettype wire

/* logic/coi_interp.v */
// Console output sequence interpreter top level
`timescale 1ns/1ps
`default_nettype none
`include "coi_regs.vh"
module coi_interp (
  input wire clk,
  input wire reset,
  input wire in_valid,
  input wire [15:0] in_char,
  input wire wide_mode,
  output wire in_ready,
  output reg put_valid_r,
  output reg [6:0] put_row_r,
  output reg [6:0] put_col_r,
  output reg [15:0] put_glyph_r,
  output reg put_subst_r,
  output reg [2:0] put_fg_r,
  output reg [2:0] put_bg_r,
  output reg put_bold_r,
  output reg put_ul_r,
  output reg put_rev_r,
  output reg erase_valid_r,
  output reg erase_line_r,
  output reg [1:0] erase_kind_r,
  output reg newline_r,
  output reg bell_r,
  output reg [6:0] cur_row_r,
  output reg [6:0] cur_col_r,
  output reg [2:0] fg_r,
  output reg [2:0] bg_r,
  output reg bold_r,
  output reg ul_r,
  output reg rev_r
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0] state_r;
  reg [7:0] par0_r;
  reg [7:0] par1_r;
  reg [7:0] acc_r;
  reg acc_seen_r;
  reg [1:0] npar_r;
  reg seq_bad_r;
  wire [15:0] g_glyph;
  wire g_subst;
  wire [7:0] cur_par;
  wire is_digit;
  wire is_final;

  assign in_ready = 1'b1;
  assign is_digit = in_char >= `COI_C_D0 && in_char <= `COI_C_D9;
  assign is_final = in_char >= `COI_C_FIN_LO && in_char <= `COI_C_FIN_HI;
  assign cur_par = acc_r;

  coi_glyph_map u_glyph (
    .code(in_char),
    .wide_mode(wide_mode),
    .glyph(g_glyph),
    .substituted(g_subst)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Decimal accumulate, saturating so long digit runs cannot wrap
  function [7:0] dec_acc;
    input [7:0] acc;
    input [15:0] ch;
    reg [11:0] t;
    begin
      t = {4'h0, acc} * 12'd10 + {8'h00, ch[3:0]};
      if (t > {4'h0, `COI_PMAX})
        dec_acc = `COI_PMAX;
      else
        dec_acc = t[7:0];
    end
  endfunction

  // Count parameter: absent or zero means one
  function [6:0] cnt1;
    input [7:0] p;
    begin
      if (p == 8'h00)
        cnt1 = 7'd1;
      else if (p > {1'b0, `COI_COLS})
        cnt1 = `COI_COLS;
      else
        cnt1 = p[6:0];
    end
  endfunction

  function [6:0] clamp_add;
    input [6:0] a;
    input [6:0] n;
    input [6:0] lim;
    reg [7:0] s;
    begin
      s = {1'b0, a} + {1'b0, n};
      clamp_add = (s > {1'b0, lim}) ? lim : s[6:0];
    end
  endfunction

  function [6:0] clamp_sub;
    input [6:0] a;
    input [6:0] n;
    begin
      clamp_sub = (n > a) ? 7'd0 : a - n;
    end
  endfunction

  // Position parameter is one-based on the wire, zero-based here
  function [6:0] pos0;
    input [7:0] p;
    input [6:0] lim;
    begin
      if (p == 8'h00)
        pos0 = 7'd0;
      else if (p > {1'b0, lim} + 8'd1)
        pos0 = lim;
      else
        pos0 = p[6:0] - 7'd1;
    end
  endfunction

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  // Rendition applies one parameter; called once per ';' of any sequence and at final 'm'
  task apply_sgr;
    input [7:0] p;
    begin
      if (p == `COI_SGR_OFF) begin
        fg_r <= `COI_FG_RST;
        bg_r <= `COI_BG_RST;
        bold_r <= 1'b0;
        ul_r <= 1'b0;
        rev_r <= 1'b0;
      end else if (p == `COI_SGR_BOLD) begin
        bold_r <= 1'b1;
      end else if (p == `COI_SGR_UL) begin
        ul_r <= 1'b1;
      end else if (p == `COI_SGR_REV) begin
        rev_r <= 1'b1;
      end else if (p >= `COI_SGR_FG_LO && p <= `COI_SGR_FG_HI) begin
        fg_r <= p[2:0] - 3'd6;
      end else if (p >= `COI_SGR_BG_LO && p <= `COI_SGR_BG_HI) begin
        bg_r <= p[2:0];
      end
    end
  endtask

  always @(posedge clk) begin
    put_valid_r <= 1'b0;
    erase_valid_r <= 1'b0;
    newline_r <= 1'b0;
    bell_r <= 1'b0;
    if (reset) begin
      state_r <= `COI_ST_GND;
      par0_r <= 8'h00;
      par1_r <= 8'h00;
      acc_r <= 8'h00;
      acc_seen_r <= 1'b0;
      npar_r <= 2'd0;
      seq_bad_r <= 1'b0;
      cur_row_r <= 7'd0;
      cur_col_r <= 7'd0;
      fg_r <= `COI_FG_RST;
      bg_r <= `COI_BG_RST;
      bold_r <= 1'b0;
      ul_r <= 1'b0;
      rev_r <= 1'b0;
      put_row_r <= 7'd0;
      put_col_r <= 7'd0;
      put_glyph_r <= 16'h0000;
      put_subst_r <= 1'b0;
      put_fg_r <= `COI_FG_RST;
      put_bg_r <= `COI_BG_RST;
      put_bold_r <= 1'b0;
      put_ul_r <= 1'b0;
      put_rev_r <= 1'b0;
      erase_line_r <= 1'b0;
      erase_kind_r <= 2'd0;
    end else if (in_valid) begin
      case (state_r)
        `COI_ST_GND: begin
          if (in_char == `COI_C_CSI) begin
            state_r <= `COI_ST_PAR;
            acc_r <= 8'h00;
            acc_seen_r <= 1'b0;
            npar_r <= 2'd0;
            seq_bad_r <= 1'b0;
            par0_r <= 8'h00;
            par1_r <= 8'h00;
          end else if (in_char == `COI_C_ESC) begin
            state_r <= `COI_ST_ESC;
          end else if (in_char == `COI_C_NUL) begin
            state_r <= `COI_ST_GND;
          end else if (in_char == `COI_C_BEL) begin
            bell_r <= 1'b1;
          end else if (in_char == `COI_C_BS) begin
            if (cur_col_r != 7'd0)
              cur_col_r <= cur_col_r - 7'd1;
          end else if (in_char == `COI_C_HT) begin
            cur_col_r <= clamp_add(cur_col_r & ~`COI_TAB_MASK,
                                   `COI_TAB_STEP, `COI_LAST_COL);
          end else if (in_char == `COI_C_LF || in_char == `COI_C_VT ||
                       in_char == `COI_C_FF) begin
            // bottom line requests a scroll from the display
            newline_r <= 1'b1;
            if (cur_row_r != `COI_LAST_ROW)
              cur_row_r <= cur_row_r + 7'd1;
          end else if (in_char == `COI_C_CR) begin
            cur_col_r <= 7'd0;
          end else if (in_char < `COI_C_SP) begin
            state_r <= `COI_ST_GND;
          end else if (cur_col_r < `COI_COLS) begin
            // past the margin the character is dropped
            put_valid_r <= 1'b1;
            put_row_r <= cur_row_r;
            put_col_r <= cur_col_r;
            put_glyph_r <= g_glyph;
            put_subst_r <= g_subst;
            put_fg_r <= fg_r;
            put_bg_r <= bg_r;
            put_bold_r <= bold_r;
            put_ul_r <= ul_r;
            put_rev_r <= rev_r;
            // only left-to-right glyphs are in the font
            cur_col_r <= cur_col_r + 7'd1;
          end
        end
        `COI_ST_ESC: begin
          if (in_char == `COI_C_LBR) begin
            state_r <= `COI_ST_PAR;
            acc_r <= 8'h00;
            acc_seen_r <= 1'b0;
            npar_r <= 2'd0;
            seq_bad_r <= 1'b0;
            par0_r <= 8'h00;
            par1_r <= 8'h00;
          end else begin
            state_r <= `COI_ST_GND;
          end
        end
        `COI_ST_PAR: begin
          if (is_digit) begin
            acc_r <= dec_acc(acc_r, in_char);
            acc_seen_r <= 1'b1;
          end else if (in_char == `COI_C_SEMI) begin
            apply_sgr(cur_par);
            if (npar_r == 2'd0)
              par0_r <= cur_par;
            else if (npar_r == 2'd1)
              par1_r <= cur_par;
            if (npar_r != 2'd3)
              npar_r <= npar_r + 2'd1;
            acc_r <= 8'h00;
            acc_seen_r <= 1'b0;
          end else if (is_final && !seq_bad_r) begin
            state_r <= `COI_ST_GND;
            if (in_char == `COI_F_M) begin
              apply_sgr(cur_par);
            end else if (in_char == `COI_F_H || in_char == `COI_F_F) begin
              if (npar_r == 2'd0) begin
                cur_row_r <= pos0(cur_par, `COI_LAST_ROW);
                cur_col_r <= 7'd0;
              end else begin
                cur_row_r <= pos0(par0_r, `COI_LAST_ROW);
                cur_col_r <= pos0(cur_par, `COI_LAST_COL);
              end
            end else if (in_char == `COI_F_A) begin
              cur_row_r <= clamp_sub(cur_row_r, cnt1(cur_par));
            end else if (in_char == `COI_F_B) begin
              cur_row_r <= clamp_add(cur_row_r, cnt1(cur_par),
                                     `COI_LAST_ROW);
            end else if (in_char == `COI_F_C) begin
              cur_col_r <= clamp_add(cur_col_r, cnt1(cur_par),
                                     `COI_LAST_COL);
            end else if (in_char == `COI_F_D) begin
              cur_col_r <= clamp_sub(cur_col_r, cnt1(cur_par));
            end else if ((in_char == `COI_F_J || in_char == `COI_F_K) &&
                         cur_par <= {6'h00, `COI_ER_ALL}) begin
              erase_valid_r <= 1'b1;
              erase_line_r <= (in_char == `COI_F_K);
              erase_kind_r <= cur_par[1:0];
              if (cur_par[1:0] == `COI_ER_ALL) begin
                cur_col_r <= 7'd0;
                if (in_char == `COI_F_J)
                  cur_row_r <= 7'd0;
              end
            end
            // Any other final is dropped quietly
          end else if (is_final) begin
            state_r <= `COI_ST_GND;
          end else if (in_char < `COI_C_SP || in_char > `COI_C_FIN_HI) begin
            // Stray control or non-ASCII aborts; it is not printed
            state_r <= `COI_ST_GND;
          end else begin
            // Intermediates such as '?' or blanks poison the sequence
            seq_bad_r <= 1'b1;
          end
        end
        default: begin
          state_r <= `COI_ST_GND;
        end
      endcase
    end
  end
endmodule // coi_interp
`default_nettype wire

/* verification/coi_interp_sva.sv */
// Checker for the console output sequence interpreter
`timescale 1ns/1ps
`default_nettype none
module coi_interp_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [15:0] in_char,
  input wire logic in_ready,
  input wire logic put_valid_r,
  input wire logic [6:0] put_row_r,
  input wire logic [6:0] put_col_r,
  input wire logic [15:0] put_glyph_r,
  input wire logic put_subst_r,
  input wire logic [2:0] put_fg_r,
  input wire logic newline_r,
  input wire logic bell_r,
  input wire logic [6:0] cur_row_r,
  input wire logic [6:0] cur_col_r,
  input wire logic [2:0] fg_r
);
  logic esc_r;
  logic seq_r;
  wire tk;
  // ----------------------------------------------------------------
  // Sequence tracking
  // ----------------------------------------------------------------
  // Characters inside a sequence are excluded from the plain checks
  assign tk = in_valid && !esc_r && !seq_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      esc_r <= 1'b0;
      seq_r <= 1'b0;
    end else if (in_valid) begin
      // Mirrors the design: blanks and '?' keep a poisoned sequence open
      esc_r <= !esc_r && !seq_r && in_char == 16'h001B;
      seq_r <= (!esc_r && !seq_r && in_char == 16'h009B) ||
        (esc_r && in_char == 16'h005B) ||
        (seq_r && in_char inside {[16'h0020:16'h003F]});
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_READY: assert property (in_ready == 1'b1)
    else $error("ready dropped");
  AST_NUL: assert property (tk && in_char == 16'h0000 |=>
    !put_valid_r && $stable(cur_col_r) && $stable(cur_row_r))
    else $error("null had an effect");
  AST_BELL: assert property (tk && in_char == 16'h0007 |=> bell_r)
    else $error("no bell pulse");
  AST_BS: assert property (tk && in_char == 16'h0008 |=>
    cur_col_r == ($past(cur_col_r) == 7'd0 ? 7'd0 : $past(cur_col_r) - 7'd1))
    else $error("backspace column wrong");
  AST_HT: assert property (tk && in_char == 16'h0009 && cur_col_r < 7'd80 |=>
    cur_col_r == (($past(cur_col_r) | 7'h07) >= 7'd79 ? 7'd79 :
    ($past(cur_col_r) | 7'h07) + 7'd1) && $stable(cur_row_r))
    else $error("tab column wrong");
  AST_CR: assert property (tk && in_char == 16'h000D |=>
    cur_col_r == 7'd0 && $stable(cur_row_r))
    else $error("return column wrong");
  AST_LF: assert property (tk && in_char inside {[16'h000A:16'h000C]} |=>
    newline_r && cur_row_r ==
    ($past(cur_row_r) == 7'd24 ? 7'd24 : $past(cur_row_r) + 7'd1))
    else $error("new line wrong");
  AST_PUT: assert property (tk && in_char inside {[16'h0020:16'h007E]} &&
    cur_col_r < 7'd80 |=> put_valid_r &&
    put_glyph_r == $past(in_char) && put_fg_r == $past(fg_r) &&
    put_col_r == $past(cur_col_r) && put_row_r == $past(cur_row_r) &&
    cur_col_r == $past(cur_col_r) + 7'd1)
    else $error("print wrong");
  AST_DROP: assert property (tk && in_char inside {[16'h0020:16'h007E]} &&
    cur_col_r >= 7'd80 |=> !put_valid_r)
    else $error("overflow printed");
  AST_SUBST: assert property (put_valid_r && put_subst_r |->
    put_glyph_r == 16'h2592)
    else $error("wrong substitute");
  cover property (put_valid_r && put_subst_r);
  cover property (bell_r);
  cover property (tk && in_char == 16'h009B);
endmodule // coi_interp_sva
`default_nettype wire

/* verification/coi_host_model.sv */
// Host model that writes the character stream
`timescale 1ns/1ps
`default_nettype none
module coi_host_model (
  input wire logic clk,
  output logic in_valid,
  output logic [15:0] in_char
);
  initial begin
    in_valid = 1'b0;
    in_char = 16'h0000;
  end
  // Writer never waits: there is no flow control to honour
  task automatic send(input logic [15:0] c);
    @(posedge clk);
    in_valid <= 1'b1;
    in_char <= c;
  endtask
  // Idle data is inverted so nothing leans on a stale code
  task automatic idle();
    @(posedge clk);
    in_valid <= 1'b0;
    in_char <= ~in_char;
    // Return after the falling edge so pulse counters have caught up
    @(negedge clk);
    #1;
  endtask
  // Parameters as bare decimal digits, no blanks between fields
  task automatic str(input string s);
    for (int i = 0; i < s.len(); i++) send({8'h00, s[i]});
    idle();
  endtask
endmodule // coi_host_model
`default_nettype wire

/* verification/coi_interp_tb_top.sv */
// Testbench for the console output sequence interpreter
`timescale 1ns/1ps
`default_nettype none
module coi_interp_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wide_mode = 1'b0;
  logic in_valid;
  logic [15:0] in_char;
  wire in_ready, put_valid_r, put_subst_r, newline_r, bell_r;
  wire bold_r, ul_r, rev_r, put_bold_r, put_ul_r, put_rev_r;
  wire erase_valid_r, erase_line_r;
  wire [1:0] erase_kind_r;
  wire [6:0] put_row_r, put_col_r, cur_row_r, cur_col_r;
  wire [15:0] put_glyph_r;
  wire [2:0] put_fg_r, put_bg_r, fg_r, bg_r;
  int fails = 0;
  int total_checks = 0;
  int puts = 0;
  always #10 clk = ~clk;
  always @(negedge clk) if (put_valid_r === 1'b1) puts++;
  coi_host_model coi_host_model_i (.clk, .in_valid, .in_char);
  coi_interp coi_interp_i (.clk, .reset, .in_valid, .in_char, .wide_mode,
    .in_ready, .put_valid_r, .put_row_r, .put_col_r, .put_glyph_r,
    .put_subst_r, .put_fg_r, .put_bg_r, .put_bold_r, .put_ul_r,
    .put_rev_r, .erase_valid_r, .erase_line_r, .erase_kind_r,
    .newline_r, .bell_r, .cur_row_r, .cur_col_r, .fg_r, .bg_r, .bold_r,
    .ul_r, .rev_r);
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic tx(input string s);
    coi_host_model_i.str(s);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_print();
    tx("A");
    chk(put_valid_r === 1'b1 && put_glyph_r === 16'h0041, "put");
    chk(put_row_r === 7'd0 && put_col_r === 7'd0, "put pos");
    chk(cur_col_r === 7'd1 && fg_r === 3'h7, "advance");
  endtask
  task automatic t_sgr();
    tx("\033[1;4;7;31;42m");
    chk(fg_r === 3'h1 && bg_r === 3'h2, "colours");
    chk({bold_r, ul_r, rev_r} === 3'b111, "flags");
    tx("B");
    chk(put_fg_r === 3'h1, "attr kept");
    chk(put_bg_r === 3'h2, "bg kept");
    chk({put_bold_r, put_ul_r, put_rev_r} === 3'b111, "put flags");
    tx("\033[31;0m");
    chk(fg_r === 3'h7 && bg_r === 3'h0, "clear");
    chk({bold_r, ul_r, rev_r} === 3'b000, "flags off");
    for (int i = 0; i < 8; i++) begin
      tx($sformatf("\033[3%0d;4%0dm", i, 7 - i));
      chk(fg_r === i[2:0] && bg_r === 3'(7 - i), "colour");
    end
  endtask
  task automatic t_ctl();
    int p;
    tx("\015\011");
    chk(cur_col_r === 7'd8, "tab");
    tx("\010");
    chk(cur_col_r === 7'd7, "bs");
    tx("\015\010");
    chk(cur_col_r === 7'd0, "bs margin");
    tx("\033[1;76H\011");
    chk(cur_col_r === 7'd79, "tab margin");
    tx("\011Z");
    chk(put_col_r === 7'd79 && cur_col_r === 7'd80, "last col");
    p = puts;
    tx("Y");
    chk(puts === p && cur_col_r === 7'd80, "overflow");
    for (int i = 10; i < 13; i++) begin
      p = cur_row_r;
      tx($sformatf("%c", i));
      chk(newline_r === 1'b1 && cur_row_r === 7'(p + 1), "lf");
    end
    tx("\033[25;1H\012");
    chk(cur_row_r === 7'd24, "last row");
    tx("\007");
    chk(bell_r === 1'b1, "bell");
    p = puts;
    coi_host_model_i.send(16'h0000);
    coi_host_model_i.idle();
    chk(puts === p && cur_col_r === 7'd0, "null");
  endtask
  task automatic t_move();
    tx("\033[5;10H");
    chk(cur_row_r === 7'd4 && cur_col_r === 7'd9, "goto");
    tx("\033[2A\033[B\033[3C");
    chk(cur_row_r === 7'd3 && cur_col_r === 7'd12, "moves");
    tx("\033[20D");
    chk(cur_col_r === 7'd0, "left clamp");
    tx("\033[1K");
    chk(erase_valid_r === 1'b1 && erase_line_r === 1'b1, "el");
    chk(erase_kind_r === 2'd1, "el kind");
    tx("\033[9C\033[2K");
    chk(erase_valid_r === 1'b1 && erase_kind_r === 2'd2, "el all");
    chk(cur_row_r === 7'd3 && cur_col_r === 7'd0, "el home");
    tx("\033[2J");
    chk(erase_valid_r === 1'b1 && erase_line_r === 1'b0, "ed");
    chk(cur_row_r === 7'd0 && cur_col_r === 7'd0, "ed home");
    tx("\033[3J");
    chk(erase_valid_r === 1'b0 && erase_kind_r === 2'd2, "ed bad");
  endtask
  task automatic t_wide();
    int p;
    @(posedge clk) wide_mode <= 1'b1;
    p = puts;
    coi_host_model_i.send(16'h2500);
    coi_host_model_i.send(16'h4E00);
    coi_host_model_i.idle();
    chk(put_subst_r === 1'b1 && put_glyph_r === 16'h2592, "subst");
    chk(puts === p + 2, "two puts");
    tx("\176");
    chk(put_glyph_r === 16'h007E && put_subst_r === 1'b0, "ascii");
    coi_host_model_i.send(16'h257F);
    coi_host_model_i.idle();
    chk(put_glyph_r === 16'h257F && put_subst_r === 1'b0, "box");
    coi_host_model_i.send(16'h009B);
    tx("32m");
    chk(fg_r === 3'h2, "wide csi");
    p = puts;
    coi_host_model_i.send(16'h009B);
    tx("?5m");
    chk(puts === p && fg_r === 3'h2, "malformed");
    tx("q");
    chk(put_glyph_r === 16'h0071, "resume");
    @(posedge clk) wide_mode <= 1'b0;
    coi_host_model_i.send(16'h00E9);
    coi_host_model_i.idle();
    chk(put_glyph_r === 16'h00E9 && put_subst_r === 1'b0, "latin");
    coi_host_model_i.send(16'h2500);
    coi_host_model_i.idle();
    chk(put_glyph_r === 16'h2592 && put_subst_r === 1'b1, "byte");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(cur_row_r === 7'd0 && cur_col_r === 7'd0 && bg_r === 3'h0 &&
      fg_r === 3'h7 && bell_r === 1'b0, "reset");
    t_print();
    t_sgr();
    t_ctl();
    t_move();
    t_wide();
    stop_test();
  end
  initial begin
    #(20 * 4000);
    fails++;
    stop_test();
  end
endmodule // coi_interp_tb_top
bind coi_interp coi_interp_sva coi_interp_sva_i (.clk, .reset, .in_valid,
  .in_char, .in_ready, .put_valid_r, .put_row_r, .put_col_r, .put_glyph_r,
  .put_subst_r, .put_fg_r, .newline_r, .bell_r, .cur_row_r, .cur_col_r,
  .fg_r);
`default_nettype wire
